/* design/gcwd_decoder.sv */
/*
 * Gateway control word decoder: holds the host control word, decodes it
 * into handshake flags, an exchange gate and node enable commands, and
 * serves the companion status word.
 * Assumes byte writes and reads from the fieldbus side area on CLOCK, and
 * a sub-network scheduler that reads the node enable vector.
 */
module gcwd_decoder #(
    parameter int NODES = 256
) (
    // Clock and reset
    input  wire logic                CLOCK,
    input  wire logic                SYS_RST,
    // Configuration
    input  wire logic                REGS_ENABLE,
    input  wire gcwd_pkg::gcwd_mode_t MODE,
    // Area byte port
    input  wire logic [9:0]          ADDR,
    input  wire logic                WR_EN,
    input  wire logic [7:0]          WR_DATA,
    output logic [7:0]               RD_DATA,
    // Status sources from the gateway
    input  wire gcwd_pkg::gcwd_status_t STATUS_IN,
    // Decoded outputs
    output gcwd_pkg::gcwd_ctrl_t     CTRL_WORD,
    output logic                     EXCHANGE_EN,
    output logic [NODES-1:0]         NODE_ENABLE,
    output logic                     CMD_DONE
);
    // Control word register and its byte write strobes.
    logic [15:0]      ctrl_reg;
    logic [15:0]      ctrl_next;
    logic             wr_hi;
    logic             wr_lo;
    // Execute edge tracking.
    logic             exec_prev_reg;
    logic             exec_prev_next;
    logic             exec_rise;
    // Command decode.
    logic             poll_mode;
    logic             cmd_run;
    logic             cmd_known;
    logic             arg_in_range;
    logic             node_disable;
    logic             node_enable_one;
    logic             node_enable_count;
    logic [3:0]       code;
    logic [7:0]       arg;
    // Node enables, one flip-flop per node.
    logic [NODES-1:0] node_reg;
    logic [NODES-1:0] node_next;
    // Command completion pulse.
    logic             done_reg;
    logic             done_next;
    // Read side of the area port.
    logic [7:0]       rd_reg;
    logic [7:0]       rd_next;
    logic             rd_stat_hi;
    logic             rd_stat_lo;
    logic             rd_ctrl_hi;
    logic             rd_ctrl_lo;
    logic [15:0]      status_word;

    assign code = ctrl_reg[gcwd_pkg::CODE_MSB:gcwd_pkg::CODE_LSB];
    assign arg  = ctrl_reg[gcwd_pkg::ARG_MSB:0];
    assign status_word = STATUS_IN;

    // The even offset carries the high byte, the odd one the low byte.
    assign wr_hi = WR_EN && REGS_ENABLE
                   && (ADDR == gcwd_pkg::CTRL_OFFSET);
    assign wr_lo = WR_EN && REGS_ENABLE
                   && (ADDR == gcwd_pkg::CTRL_OFFSET + 10'h001);

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_hi) begin
            ctrl_next[15:8] = WR_DATA;
        end
        if (wr_lo) begin
            ctrl_next[7:0] = WR_DATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctrl_reg <= gcwd_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // A held execute bit must not repeat the command.
    always_comb begin
        exec_prev_next = ctrl_reg[gcwd_pkg::EXEC_BIT];
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            exec_prev_reg <= 1'b0;
        end else begin
            exec_prev_reg <= exec_prev_next;
        end
    end

    assign exec_rise = REGS_ENABLE && ctrl_reg[gcwd_pkg::EXEC_BIT]
                       && !exec_prev_reg;

    // Node commands exist only in the polling-master modes.
    assign poll_mode = (MODE == gcwd_pkg::GCWD_MODE_MASTER)
                       || (MODE == gcwd_pkg::GCWD_MODE_LEGACY_SERIAL);
    assign cmd_run = exec_rise && poll_mode;
    assign node_disable      = cmd_run && (code == gcwd_pkg::CMD_DISABLE);
    assign node_enable_one   = cmd_run && (code == gcwd_pkg::CMD_ENABLE);
    assign node_enable_count = cmd_run && (code == gcwd_pkg::CMD_ENABLE_N);
    assign cmd_known = node_disable || node_enable_one || node_enable_count;
    assign arg_in_range = 32'(arg) < NODES;

    // Each node decides its own next enable value.
    for (genvar n = 0; n < NODES; n++) begin : g_node
        always_comb begin
            node_next[n] = node_reg[n];
            if (node_disable && arg_in_range && (32'(arg) == n)) begin
                node_next[n] = 1'b0;
            end
            if (node_enable_one && arg_in_range && (32'(arg) == n)) begin
                node_next[n] = 1'b1;
            end
            if (node_enable_count) begin
                node_next[n] = (n < 32'(arg));
            end
        end

        always_ff @(posedge CLOCK) begin
            if (SYS_RST) begin
                node_reg[n] <= 1'b1;
            end else begin
                node_reg[n] <= node_next[n];
            end
        end
    end

    // Unknown codes and transparent mode give no completion pulse.
    always_comb begin
        done_next = cmd_known;
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    // Unmapped offsets and disabled registers read as zero.
    assign rd_stat_hi = REGS_ENABLE && (ADDR == gcwd_pkg::STATUS_OFFSET);
    assign rd_stat_lo = REGS_ENABLE
                        && (ADDR == gcwd_pkg::STATUS_OFFSET + 10'h001);
    assign rd_ctrl_hi = REGS_ENABLE && (ADDR == gcwd_pkg::CTRL_OFFSET);
    assign rd_ctrl_lo = REGS_ENABLE
                        && (ADDR == gcwd_pkg::CTRL_OFFSET + 10'h001);

    always_comb begin
        rd_next = 8'h00;
        if (rd_stat_hi) begin
            rd_next = status_word[15:8];
        end else if (rd_stat_lo) begin
            rd_next = status_word[7:0];
        end else if (rd_ctrl_hi) begin
            rd_next = ctrl_reg[15:8];
        end else if (rd_ctrl_lo) begin
            rd_next = ctrl_reg[7:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign CTRL_WORD   = ctrl_reg;
    // Without the registers the gate is ignored and exchange always runs.
    assign EXCHANGE_EN = REGS_ENABLE ? ctrl_reg[gcwd_pkg::VALID_BIT]
                                     : 1'b1;
    assign NODE_ENABLE = node_reg;
    assign CMD_DONE    = done_reg;
    assign RD_DATA     = rd_reg;
endmodule

/* design/gcwd_pkg.sv */
/*
 * Constants and carrier types of the gateway control word decoder.
 * Assumes a single clock domain and a byte-wide area memory port.
 */
package gcwd_pkg;
    localparam logic [9:0] CTRL_OFFSET   = 10'h200;
    localparam logic [9:0] STATUS_OFFSET = 10'h000;
    localparam int         HI_BIT        = 15;
    localparam int         CONFIRM_BIT   = 15;
    localparam int         SEND_BIT      = 14;
    localparam int         VALID_BIT     = 13;
    localparam int         EXEC_BIT      = 12;
    localparam int         CODE_MSB      = 11;
    localparam int         CODE_LSB      = 8;
    localparam int         ARG_MSB       = 7;
    localparam int         STAT_MSB      = 12;
    localparam logic [3:0] CMD_DISABLE   = 4'h0;
    localparam logic [3:0] CMD_ENABLE    = 4'h1;
    localparam logic [3:0] CMD_ENABLE_N  = 4'h2;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [4:0] STAT_NO_ERROR = 5'h1F;

    typedef enum logic [1:0] {
        GCWD_MODE_MASTER        = 2'b00,
        GCWD_MODE_LEGACY_SERIAL = 2'b01,
        GCWD_MODE_TRANSPARENT   = 2'b10
    } gcwd_mode_t;

    typedef struct packed {
        logic       host_confirm_flag;
        logic       host_send_flag;
        logic       output_valid;
        logic       execute;
        logic [3:0] code;
        logic [7:0] arg;
    } gcwd_ctrl_t;

    typedef struct packed {
        logic       gateway_send_flag;
        logic       gateway_confirm_flag;
        logic       data_valid;
        logic [4:0] code;
        logic [7:0] arg;
    } gcwd_status_t;
endpackage

/* testbench/gcwd_dec_assertions.sv */
/* Port assertions for the control word decoder.
   Assumes it is bound into every decoder instance. */
module gcwd_dec_assertions #(parameter int NODES = 256) (
    // Inputs
    input wire logic                   CLOCK,
    input wire logic                   SYS_RST,
    input wire logic                   REGS_ENABLE,
    input wire gcwd_pkg::gcwd_mode_t   MODE,
    input wire logic [9:0]             ADDR,
    input wire logic                   WR_EN,
    input wire logic [7:0]             WR_DATA,
    input wire gcwd_pkg::gcwd_status_t STATUS_IN,
    // Outputs
    input wire logic [7:0]             RD_DATA,
    input wire gcwd_pkg::gcwd_ctrl_t   CTRL_WORD,
    input wire logic                   EXCHANGE_EN,
    input wire logic [NODES-1:0]       NODE_ENABLE,
    input wire logic                   CMD_DONE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    wire wr_ok = WR_EN && REGS_ENABLE;
    hi_byte_a: assert property (
        wr_ok && ADDR == 10'h200 |=> CTRL_WORD[15:8] == $past(WR_DATA)
    ) else $error("high byte lost");
    lo_byte_a: assert property (
        wr_ok && ADDR == 10'h201 |=> CTRL_WORD[7:0] == $past(WR_DATA)
    ) else $error("low byte lost");
    regs_off_a: assert property (
        !REGS_ENABLE |=> $stable(CTRL_WORD)) else $error("write taken");
    exch_gate_a: assert property (
        EXCHANGE_EN == (REGS_ENABLE ? CTRL_WORD[13] : 1'b1)
    ) else $error("exchange gate wrong");
    stat_hi_a: assert property (
        REGS_ENABLE && ADDR == 10'h000 |=> RD_DATA == $past(STATUS_IN[15:8])
    ) else $error("status high byte wrong");
    done_once_a: assert property (
        CMD_DONE |-> $past(CTRL_WORD[12]) && !$past(CTRL_WORD[12], 2)
    ) else $error("command without execute rise");
    no_transp_a: assert property (
        CMD_DONE |-> $past(MODE) != gcwd_pkg::GCWD_MODE_TRANSPARENT
    ) else $error("command in transparent mode");
    node_sel_a: assert property (
        CMD_DONE && $past(CTRL_WORD[11:8]) <= 4'h1
            && $past(CTRL_WORD[7:0]) < NODES
        |-> NODE_ENABLE[$past(CTRL_WORD[7:0])] == $past(CTRL_WORD[8])
    ) else $error("node enable wrong");
endmodule
bind gcwd_decoder gcwd_dec_assertions #(.NODES(NODES)) i_chk (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .REGS_ENABLE(REGS_ENABLE),
    .MODE(MODE), .ADDR(ADDR), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA), .STATUS_IN(STATUS_IN), .CTRL_WORD(CTRL_WORD),
    .EXCHANGE_EN(EXCHANGE_EN), .NODE_ENABLE(NODE_ENABLE),
    .CMD_DONE(CMD_DONE));

/* testbench/gcwd_host_model.sv */
/* Fieldbus host model: writes the control word, reads the area.
   Assumes one byte is taken per clock while WR_EN is high. */
module gcwd_host_model (
    // Clock and read data
    input wire logic       CLOCK,
    input wire logic [7:0] RD_DATA,
    // Area byte port
    output logic [9:0]     ADDR,
    output logic           WR_EN,
    output logic [7:0]     WR_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ADDR = 10'h000;
        WR_EN = 1'b0;
        WR_DATA = 8'h00;
    end
    // Low byte first, so the argument is in place when execute rises.
    task automatic word(input logic [15:0] w);
        @(posedge CLOCK);
        ADDR <= 10'h201;
        WR_EN <= 1'b1;
        WR_DATA <= w[7:0];
        @(posedge CLOCK);
        ADDR <= 10'h200;
        WR_DATA <= w[15:8];
        @(posedge CLOCK);
        WR_EN <= 1'b0;
        WR_DATA <= ~w[15:8];
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        @(posedge CLOCK);
        #1 d = RD_DATA;
    endtask
endmodule

/* testbench/tb_gateway_control_word_decoder.sv */
/* Self-checking bench for the control word decoder, eight nodes.
   Assumes the host model drives the area port. */
module tb_gateway_control_word_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, sys_rst, regs_en, wr_en, exch_en, done;
    logic [9:0] addr;
    logic [7:0] wr_data, rd_data, node_en, rdv;
    gcwd_pkg::gcwd_mode_t mode = gcwd_pkg::GCWD_MODE_MASTER;
    gcwd_pkg::gcwd_status_t status_in = gcwd_pkg::gcwd_status_t'(16'hD1F5);
    gcwd_pkg::gcwd_ctrl_t ctrl_word;
    int n_fail = 0;
    int checks = 0;
    // Each row: mode, control word, node enables after it, done pulse.
    logic [26:0] rows [8] = '{{2'h0, 16'h1003, 8'hF7, 1'h1},
        {2'h1, 16'h1103, 8'hFF, 1'h1}, {2'h0, 16'h1205, 8'h1F, 1'h1},
        {2'h2, 16'h1107, 8'h1F, 1'h0}, {2'h0, 16'h1300, 8'h1F, 1'h0},
        {2'h0, 16'h1009, 8'h1F, 1'h1}, {2'h1, 16'h1208, 8'hFF, 1'h1},
        {2'h0, 16'h3007, 8'h7F, 1'h1}};
    gcwd_decoder #(.NODES(8)) i_gcwd_decoder (.CLOCK(clock),
        .SYS_RST(sys_rst), .REGS_ENABLE(regs_en), .MODE(mode),
        .ADDR(addr), .WR_EN(wr_en), .WR_DATA(wr_data), .RD_DATA(rd_data),
        .STATUS_IN(status_in), .CTRL_WORD(ctrl_word),
        .EXCHANGE_EN(exch_en), .NODE_ENABLE(node_en), .CMD_DONE(done));
    gcwd_host_model i_host (.CLOCK(clock), .RD_DATA(rd_data), .ADDR(addr),
        .WR_EN(wr_en), .WR_DATA(wr_data));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        wrap_up();
    end
    initial begin
        sys_rst = 1'b1;
        regs_en = 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            mode <= gcwd_pkg::gcwd_mode_t'(rows[k][26:25]);
            i_host.word(rows[k][24:9]);
            @(posedge clock);
            #1 chk(16'(done), 16'(rows[k][0]));
            chk(16'(node_en), 16'(rows[k][8:1]));
            chk(16'(exch_en), 16'(rows[k][22]));
            i_host.word(16'h0000);
            $display("row %0d done", k);
        end
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        #1 chk(16'(ctrl_word), 16'h0000);
        chk(16'(node_en), 16'h00FF);
        i_host.rd(10'h000, rdv);
        chk(16'(rdv), 16'h00D1);
        @(posedge clock);
        status_in <= gcwd_pkg::gcwd_status_t'(16'h2A3C);
        i_host.rd(10'h001, rdv);
        chk(16'(rdv), 16'h003C);
        i_host.rd(10'h000, rdv);
        chk(16'(rdv), 16'h002A);
        i_host.word(16'h1002);
        i_host.word(16'h1002);
        @(posedge clock);
        #1 chk(16'(done), 16'h0000);
        chk(16'(node_en), 16'h00FB);
        i_host.rd(10'h200, rdv);
        chk(16'(rdv), 16'h0010);
        $display("reset and held execute test done");
        i_host.word(16'h0000);
        #1 chk(16'(exch_en), 16'h0000);
        @(posedge clock);
        regs_en <= 1'b0;
        i_host.word(16'h2000);
        #1 chk(16'(ctrl_word), 16'h0000);
        chk(16'(exch_en), 16'h0001);
        $display("gating test done");
        wrap_up();
    end
endmodule
